// file: verilog/rf_gate_pulse_sequencer.sv
// RF output stage sequencer: gate pulse train, damping gate, relay selection, spark timing.
// Assumes synchronous inputs on pclk, an APB master for control, and an analog comparator
// that raises spark_detect when the peak output voltage passes its threshold.
//
// Behaviour
// - Topology relays follow the selected mode.
// - One of four voltage scale relays by power.
// - Current source relay; own current scale breakpoints.
// - Low/pure cut: 846 ns pulses at 390 kHz.
// - Blend cut: 50% envelope at 27 kHz.
// - Blend damping spans end of each burst.
// - Bipolar: 423 ns pulses at 470 kHz.
// - Low-crest fulgurate: 1.69 us at 57 kHz.
// - Fulgurate: 1.69 us pulses at 30 kHz.
// - Spray: random rate 21.6 to 35.23 kHz.
// - Spray: random gain select toggling.
// - Coag modes: damping each switching cycle.
// - Desiccate: 2 us pulses at 39 kHz.
// - Monopolar: return relay plus chosen receptacle.
// - Bipolar: return open, both bipolar relays.
// - Routing relays open without activation.
// - Spark detect makes a 3 ms pulse.
// - Pulse ignored first 0.2 s, else stops.
// - Pure cut: stop 100 ms, restart 470 kHz.
// - Back to 394 kHz after 1 s.
// - Leakage inhibit skips at most four cycles in a row.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module rf_gate_pulse_sequencer
    import rf_gate_pkg::*;
#(
    parameter int PW          = 9,
    parameter int SPARK_LEN   = SPARK_CYC,
    parameter int HOLDOFF_LEN = HOLDOFF_CYC,
    parameter int RESTART_LEN = RESTART_CYC,
    parameter int FAST_LEN    = FAST_CYC,
    parameter int SPRAY_MAX   = P_SPMAX_CYC,
    parameter int FULG_P      = P_FULG_CYC,
    parameter int DAMP_CYC    = 50,
    parameter int DAMP_LEAD   = 20,
    parameter int DAMP_TAIL   = 200,
    parameter int VBP1 = 50,
    parameter int VBP2 = 100,
    parameter int VBP3 = 200,
    parameter int IBP1 = 30,
    parameter int IBP2 = 80,
    parameter int IBP3 = 150
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          spark_detect,
    input  wire logic          leakage_inhibit,
    output logic               gate_drive,
    output logic               damping_switch,
    output logic               amplitude_gain_select,
    output logic               spark_inhibit_pulse,
    output logic               topology_relay_a,
    output logic               topology_relay_b,
    output logic               return_electrode_relay,
    output logic               monopolar_one_relay,
    output logic               monopolar_two_relay,
    output logic               bipolar_route_relay_a,
    output logic               bipolar_route_relay_b,
    output logic      [3:0]    voltage_scale_relays,
    output logic               current_source_relay,
    output logic      [3:0]    current_scale_relays
);
    typedef enum {SP_RUN, SP_STOP, SP_WAIT} spark_state_t;

    logic [3:0]    ctrl_mode;
    logic          ctrl_act;
    logic          ctrl_second;
    logic [PW-1:0] power;
    logic          spark_flag;
    logic          act;
    logic          running;
    logic [12:0]   cnt;
    logic [12:0]   cur_period;
    logic [12:0]   cur_width;
    logic [12:0]   sel_period;
    logic [12:0]   sel_width;
    logic [12:0]   env_cnt;
    logic [12:0]   rnd;
    logic          skip;
    logic [2:0]    skip_run;
    logic [15:0]   lfsr;
    logic [18:0]   sp_cnt;
    logic [26:0]   act_cnt;
    logic [26:0]   tmr;
    logic          fast;
    logic          ret;
    logic          holdoff_done;
    logic          cyc_end;
    logic          env_on;
    logic          spark_stop;
    logic          wr;
    logic          rd;
    spark_state_t  sp_state;

    function automatic logic mode_valid(input logic [3:0] m);
        return (m >= MODE_LOW) && (m <= MODE_DESIC);
    endfunction

    function automatic logic is_coag(input logic [3:0] m);
        return (m >= MODE_LCF) && (m <= MODE_DESIC);
    endfunction

    function automatic logic is_leak(input logic [3:0] m);
        return (m == MODE_LCF) || (m == MODE_FULG) || (m == MODE_SPRAY);
    endfunction

    function automatic logic [3:0] scale_sel(input logic [PW-1:0] p,
                                             input int b1, input int b2, input int b3);
        if (int'(p) < b1) begin
            return 4'h1;
        end else if (int'(p) < b2) begin
            return 4'h2;
        end else if (int'(p) < b3) begin
            return 4'h4;
        end
        return 4'h8;
    endfunction

    assign act          = ctrl_act && mode_valid(ctrl_mode);
    assign running      = act && (sp_state == SP_RUN);
    assign cyc_end      = (cnt == cur_period - 13'h0001);
    assign holdoff_done = (act_cnt == 27'(HOLDOFF_LEN));
    assign env_on       = (ctrl_mode != MODE_BLEND) || (env_cnt < 13'(ENV_ON_CYC));
    assign spark_stop   = spark_inhibit_pulse && holdoff_done;
    assign wr           = psel && penable && pready && pwrite;
    assign rd           = psel && !penable;

    // Fold the random word into the spray band so every period stays inside it.
    assign rnd = (lfsr[10:0] > 11'(SPRAY_SPAN)) ? 13'(lfsr[10:0] - 11'(SPRAY_SPAN))
                                                : 13'(lfsr[10:0]);

    always_comb begin
        sel_period = 13'(P_CUT_CYC);
        sel_width  = 13'(CUT_W_CYC);
        case (ctrl_mode)
            MODE_LOW: begin
                sel_period = 13'(P_CUT_CYC);
            end
            MODE_PURE: begin
                if (fast) begin
                    sel_period = 13'(P_BIP_CYC);
                end else if (ret) begin
                    sel_period = 13'(P_RET_CYC);
                end else begin
                    sel_period = 13'(P_CUT_CYC);
                end
            end
            MODE_BLEND: begin
                sel_period = 13'(P_CUT_CYC);
            end
            MODE_BIP: begin
                sel_period = 13'(P_BIP_CYC);
                sel_width  = 13'(BIP_W_CYC);
            end
            MODE_LCF: begin
                sel_period = 13'(P_LCF_CYC);
                sel_width  = 13'(FUL_W_CYC);
            end
            MODE_FULG: begin
                sel_period = 13'(FULG_P);
                sel_width  = 13'(FUL_W_CYC);
            end
            MODE_SPRAY: begin
                sel_period = 13'(P_SPMIN_CYC) + rnd;
                sel_width  = 13'(FUL_W_CYC);
            end
            MODE_DESIC: begin
                sel_period = 13'(P_DES_CYC);
                sel_width  = 13'(DES_W_CYC);
            end
            default: begin
                sel_period = 13'(P_CUT_CYC);
                sel_width  = 13'(CUT_W_CYC);
            end
        endcase
    end

    // APB slave with one wait-free access phase; pready rises for the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd;
            pslverr <= rd && (paddr != OFS_CTRL) && (paddr != OFS_POWER)
                          && (paddr != OFS_STATUS);
            if (rd && !pwrite) begin
                case (paddr)
                    OFS_CTRL: begin
                        prdata <= {26'h0, ctrl_second, ctrl_act, ctrl_mode};
                    end
                    OFS_POWER: begin
                        prdata <= 32'(power);
                    end
                    OFS_STATUS: begin
                        prdata <= {27'h0, spark_flag, !holdoff_done && act, fast,
                                   spark_inhibit_pulse, running};
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_mode   <= RST_MODE;
            ctrl_act    <= 1'b0;
            ctrl_second <= 1'b0;
            power       <= PW'(RST_POWER);
        end else if (wr && !pslverr) begin
            if (paddr == OFS_CTRL) begin
                ctrl_mode   <= pwdata[CTRL_MODE_LSB +: 4];
                ctrl_act    <= pwdata[CTRL_ACT_BIT];
                ctrl_second <= pwdata[CTRL_SEC_BIT];
            end else if (paddr == OFS_POWER) begin
                power <= pwdata[PW-1:0];
            end
        end
    end

    // Sticky spark flag: a new spark in the clearing cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spark_flag <= 1'b0;
        end else if (sp_state == SP_RUN && act && spark_stop) begin
            spark_flag <= 1'b1;
        end else if (wr && paddr == OFS_STATUS && pwdata[ST_SPARK_BIT]) begin
            spark_flag <= 1'b0;
        end
    end

    // Non-retriggerable one-shot; a spike during a running pulse does not stretch it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_cnt              <= '0;
            spark_inhibit_pulse <= 1'b0;
        end else if (!spark_inhibit_pulse && spark_detect) begin
            sp_cnt              <= 19'(SPARK_LEN - 1);
            spark_inhibit_pulse <= 1'b1;
        end else if (spark_inhibit_pulse) begin
            sp_cnt <= sp_cnt - 19'h00001;
            if (sp_cnt == '0) begin
                spark_inhibit_pulse <= 1'b0;
            end
        end
    end

    // Activation age; saturates once the spark blanking window is over.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt <= '0;
        end else begin
            if (!act) begin
                act_cnt <= '0;
            end else if (!holdoff_done) begin
                act_cnt <= act_cnt + 27'h0000001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_state <= SP_RUN;
            tmr      <= '0;
            fast     <= 1'b0;
            ret      <= 1'b0;
        end else if (!act) begin
            sp_state <= SP_RUN;
            tmr      <= '0;
            fast     <= 1'b0;
            ret      <= 1'b0;
        end else begin
            if (tmr != '0) begin
                tmr <= tmr - 27'h0000001;
            end
            case (sp_state)
                SP_RUN: begin
                    if (spark_stop) begin
                        fast <= 1'b0;
                        if (ctrl_mode == MODE_PURE) begin
                            sp_state <= SP_WAIT;
                            tmr      <= 27'(RESTART_LEN - 1);
                        end else begin
                            sp_state <= SP_STOP;
                        end
                    end else if (fast && tmr == '0) begin
                        fast <= 1'b0;
                        ret  <= 1'b1;
                    end
                end
                SP_STOP: begin
                    if (!spark_inhibit_pulse) begin
                        sp_state <= SP_RUN;
                    end
                end
                SP_WAIT: begin
                    if (tmr == '0) begin
                        sp_state <= SP_RUN;
                        fast     <= 1'b1;
                        tmr      <= 27'(FAST_LEN - 1);
                    end
                end
                default: begin
                    sp_state <= SP_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr <= LFSR_SEED;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    // Switching cycle counter; period and width are latched at each cycle start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= '0;
            cur_period <= 13'(P_CUT_CYC);
            cur_width  <= 13'(CUT_W_CYC);
        end else if (!running || cyc_end) begin
            cnt        <= '0;
            cur_period <= sel_period;
            cur_width  <= sel_width;
        end else begin
            cnt <= cnt + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            env_cnt <= '0;
        end else if (!running || ctrl_mode != MODE_BLEND
                     || env_cnt == 13'(P_ENV_CYC - 1)) begin
            env_cnt <= '0;
        end else begin
            env_cnt <= env_cnt + 13'h0001;
        end
    end

    // Leakage skips are decided per switching cycle and capped so power never stalls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip     <= 1'b0;
            skip_run <= '0;
        end else if (!running) begin
            skip     <= 1'b0;
            skip_run <= '0;
        end else if (cyc_end) begin
            if (leakage_inhibit && is_leak(ctrl_mode)
                && skip_run < 3'(LEAK_MAX_SKIP)) begin
                skip     <= 1'b1;
                skip_run <= skip_run + 3'h1;
            end else begin
                skip     <= 1'b0;
                skip_run <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_drive <= 1'b0;
        end else begin
            gate_drive <= running && !skip && env_on && (cnt < cur_width);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            damping_switch <= 1'b0;
        end else if (!running) begin
            damping_switch <= 1'b0;
        end else if (ctrl_mode == MODE_BLEND) begin
            damping_switch <= (env_cnt >= 13'(ENV_ON_CYC - DAMP_LEAD))
                           && (env_cnt < 13'(ENV_ON_CYC + DAMP_TAIL));
        end else if (is_coag(ctrl_mode)) begin
            damping_switch <= (cnt >= cur_width)
                           && (cnt < cur_width + 13'(DAMP_CYC));
        end else begin
            damping_switch <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amplitude_gain_select <= 1'b0;
        end else if (!running || ctrl_mode != MODE_SPRAY) begin
            amplitude_gain_select <= 1'b0;
        end else if (cyc_end) begin
            amplitude_gain_select <= lfsr[15];
        end
    end

    // Relays follow mode and power every cycle while activated, so they can switch mid-activation; all open once activation drops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            topology_relay_a       <= 1'b0;
            topology_relay_b       <= 1'b0;
            return_electrode_relay <= 1'b0;
            monopolar_one_relay    <= 1'b0;
            monopolar_two_relay    <= 1'b0;
            bipolar_route_relay_a  <= 1'b0;
            bipolar_route_relay_b  <= 1'b0;
            voltage_scale_relays   <= 4'h0;
            current_source_relay   <= 1'b0;
            current_scale_relays   <= 4'h0;
        end else if (!act) begin
            topology_relay_a       <= 1'b0;
            topology_relay_b       <= 1'b0;
            return_electrode_relay <= 1'b0;
            monopolar_one_relay    <= 1'b0;
            monopolar_two_relay    <= 1'b0;
            bipolar_route_relay_a  <= 1'b0;
            bipolar_route_relay_b  <= 1'b0;
            voltage_scale_relays   <= 4'h0;
            current_source_relay   <= 1'b0;
            current_scale_relays   <= 4'h0;
        end else begin
            topology_relay_a       <= !is_coag(ctrl_mode);
            topology_relay_b       <= !is_leak(ctrl_mode);
            return_electrode_relay <= (ctrl_mode != MODE_BIP);
            monopolar_one_relay    <= (ctrl_mode != MODE_BIP) && !ctrl_second;
            monopolar_two_relay    <= (ctrl_mode != MODE_BIP) && ctrl_second;
            bipolar_route_relay_a  <= (ctrl_mode == MODE_BIP);
            bipolar_route_relay_b  <= (ctrl_mode == MODE_BIP);
            voltage_scale_relays   <= scale_sel(power, VBP1, VBP2, VBP3);
            current_source_relay   <= (ctrl_mode == MODE_BIP);
            current_scale_relays   <= scale_sel(power, IBP1, IBP2, IBP3);
        end
    end
endmodule

// file: verilog/rf_gate_pkg.sv
// Constants shared by the RF gate pulse sequencer: register map, mode codes and timing.
// Assumes a 100 MHz system clock; every cycle count is derived from that rate.
package rf_gate_pkg;
    localparam int CLK_HZ  = 100_000_000;
    localparam int CLK_MHZ = 100;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_POWER  = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_BIT  = 4;
    localparam int CTRL_SEC_BIT  = 5;

    // Status register fields; the spark flag is sticky, write one to clear.
    localparam int ST_RUN_BIT   = 0;
    localparam int ST_PULSE_BIT = 1;
    localparam int ST_FAST_BIT  = 2;
    localparam int ST_HOLD_BIT  = 3;
    localparam int ST_SPARK_BIT = 4;

    // Mode codes held in the control register.
    localparam logic [3:0] MODE_OFF   = 4'h0;
    localparam logic [3:0] MODE_LOW   = 4'h1;
    localparam logic [3:0] MODE_PURE  = 4'h2;
    localparam logic [3:0] MODE_BLEND = 4'h3;
    localparam logic [3:0] MODE_BIP   = 4'h4;
    localparam logic [3:0] MODE_LCF   = 4'h5;
    localparam logic [3:0] MODE_FULG  = 4'h6;
    localparam logic [3:0] MODE_SPRAY = 4'h7;
    localparam logic [3:0] MODE_DESIC = 4'h8;

    // Reset values.
    localparam logic [3:0] RST_MODE  = MODE_OFF;
    localparam logic [8:0] RST_POWER = 9'h000;

    // Pulse widths in ns, rounded up to whole cycles.
    localparam int CUT_W_NS = 846;
    localparam int BIP_W_NS = 423;
    localparam int FUL_W_NS = 1690;
    localparam int DES_W_NS = 2000;
    localparam int CUT_W_CYC = (CUT_W_NS * CLK_MHZ + 999) / 1000;
    localparam int BIP_W_CYC = (BIP_W_NS * CLK_MHZ + 999) / 1000;
    localparam int FUL_W_CYC = (FUL_W_NS * CLK_MHZ + 999) / 1000;
    localparam int DES_W_CYC = (DES_W_NS * CLK_MHZ + 999) / 1000;

    // Repetition frequencies in Hz and their periods in cycles.
    localparam int F_CUT_HZ   = 390_000;
    localparam int F_RET_HZ   = 394_000;
    localparam int F_BIP_HZ   = 470_000;
    localparam int F_LCF_HZ   = 57_000;
    localparam int F_FULG_HZ  = 30_000;
    localparam int F_DES_HZ   = 39_000;
    localparam int F_ENV_HZ   = 27_000;
    localparam int F_SPLO_HZ  = 21_600;
    localparam int F_SPHI_HZ  = 35_230;
    localparam int P_CUT_CYC  = CLK_HZ / F_CUT_HZ;
    localparam int P_RET_CYC  = CLK_HZ / F_RET_HZ;
    localparam int P_BIP_CYC  = CLK_HZ / F_BIP_HZ;
    localparam int P_LCF_CYC  = CLK_HZ / F_LCF_HZ;
    localparam int P_FULG_CYC = CLK_HZ / F_FULG_HZ;
    localparam int P_DES_CYC  = CLK_HZ / F_DES_HZ;
    localparam int P_ENV_CYC  = CLK_HZ / F_ENV_HZ;
    localparam int ENV_DUTY_PCT = 50;
    localparam int ENV_ON_CYC   = P_ENV_CYC * ENV_DUTY_PCT / 100;
    localparam int P_SPMIN_CYC  = CLK_HZ / F_SPHI_HZ;
    localparam int P_SPMAX_CYC  = CLK_HZ / F_SPLO_HZ;
    localparam int SPRAY_SPAN   = P_SPMAX_CYC - P_SPMIN_CYC;

    // Spark handling times in ms.
    localparam int SPARK_MS   = 3;
    localparam int HOLDOFF_MS = 200;
    localparam int RESTART_MS = 100;
    localparam int FAST_MS    = 1000;
    localparam int SPARK_CYC   = CLK_HZ / 1000 * SPARK_MS;
    localparam int HOLDOFF_CYC = CLK_HZ / 1000 * HOLDOFF_MS;
    localparam int RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
    localparam int FAST_CYC    = CLK_HZ / 1000 * FAST_MS;

    localparam int LEAK_MAX_SKIP = 4;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
endpackage

// file: verif/gate_driver_model.sv
// Far-side model of the power switch gate driver: measures pulse width and period.
// Assumes gate_drive is synchronous to pclk and active high.
`timescale 1ns/1ps
module gate_driver_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        gate_drive,
    output logic      [15:0] width,
    output logic      [15:0] period
);
    logic [15:0] hi;
    logic [15:0] cyc;
    logic        g_q;

    // Period runs rise to rise, so a stretched pulse never hides a slow rate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hi, cyc, g_q, width, period} <= '0;
        end else begin
            g_q <= gate_drive;
            hi  <= gate_drive ? hi + 16'h0001 : 16'h0000;
            cyc <= (gate_drive && !g_q) ? 16'h0001 : cyc + 16'h0001;
            if (gate_drive && !g_q) period <= cyc;
            if (!gate_drive && g_q) width <= hi;
        end
    end
endmodule

// file: verif/rf_gate_asserts.sv
// Port checker for the RF gate pulse sequencer.
// Assumes it is bound into the sequencer and shares its clock and reset.
`timescale 1ns/1ps
module rf_gate_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gate_drive,
    input wire logic        spark_inhibit_pulse,
    input wire logic        topology_relay_a,
    input wire logic        topology_relay_b,
    input wire logic        return_electrode_relay,
    input wire logic        monopolar_one_relay,
    input wire logic        bipolar_route_relay_a,
    input wire logic [3:0]  voltage_scale_relays,
    input wire logic [3:0]  current_scale_relays
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready missing after setup");
    property p_err; pready && paddr > 12'h008 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_top; topology_relay_a |-> topology_relay_b; endproperty
    a_top: assert property (p_top) else $error("topology pair illegal");
    property p_vs; $onehot0(voltage_scale_relays); endproperty
    a_vs: assert property (p_vs) else $error("voltage scale not one-hot");
    property p_cs; $onehot0(current_scale_relays); endproperty
    a_cs: assert property (p_cs) else $error("current scale not one-hot");
    property p_mono; monopolar_one_relay |-> return_electrode_relay; endproperty
    a_mono: assert property (p_mono) else $error("return relay open");
    property p_bip; bipolar_route_relay_a |-> !return_electrode_relay; endproperty
    a_bip: assert property (p_bip) else $error("return relay closed");
    property p_spk; $rose(spark_inhibit_pulse) |-> spark_inhibit_pulse [*8]; endproperty
    a_spk: assert property (p_spk) else $error("spark pulse too short");
    property p_gw;
        $rose(gate_drive) |-> (gate_drive || spark_inhibit_pulse
                               || !return_electrode_relay && !bipolar_route_relay_a) [*8];
    endproperty
    a_gw: assert property (p_gw) else $error("gate pulse too short");
endmodule

bind rf_gate_pulse_sequencer rf_gate_asserts u_chk (.*);

// file: verif/rf_gate_pulse_sequencer_test.sv
// Self-checking bench for the RF gate sequencer, driven over APB.
// Assumes the gate driver model and the bound port checker.
`timescale 1ns/1ps
module rf_gate_pulse_sequencer_test;
    import rf_gate_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, spark_detect, leakage_inhibit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, gate_drive, damping_switch, amplitude_gain_select;
    logic        spark_inhibit_pulse, topology_relay_a, topology_relay_b, monopolar_one_relay;
    logic        return_electrode_relay, monopolar_two_relay, current_source_relay;
    logic        bipolar_route_relay_a, bipolar_route_relay_b;
    logic [3:0]  voltage_scale_relays, current_scale_relays;
    logic [15:0] width, period;
    int          n_errors = 0;
    int          n_tests = 0;

    rf_gate_pulse_sequencer #(.SPARK_LEN(50), .HOLDOFF_LEN(200), .RESTART_LEN(300),
        .FAST_LEN(1000)) u_dut (.*);
    gate_driver_model u_drv (.pclk(pclk), .presetn(presetn), .gate_drive(gate_drive),
        .width(width), .period(period));

    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [6:0] rly();
        return {topology_relay_a, topology_relay_b, return_electrode_relay,
            monopolar_one_relay, monopolar_two_relay, bipolar_route_relay_a,
            bipolar_route_relay_b};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic spike();
        spark_detect <= 1;
        @(posedge pclk);
        spark_detect <= 0;
    endtask

    task automatic t_reset();
        chk({gate_drive, damping_switch, rly()}, 0);
        apb(0, OFS_CTRL, 0);
        chk(rd, 0);
        apb(0, 12'h00C, 0);
        chk({31'h0, err}, 1);
        chk(rd, 0);
        $display("test reset done");
    endtask

    task automatic t_modes();
        logic [3:0] m [6] = '{MODE_LOW, MODE_PURE, MODE_BIP, MODE_LCF, MODE_FULG, MODE_DESIC};
        int w [6] = '{CUT_W_CYC, CUT_W_CYC, BIP_W_CYC, FUL_W_CYC, FUL_W_CYC, DES_W_CYC};
        int p [6] = '{P_CUT_CYC, P_CUT_CYC, P_BIP_CYC, P_LCF_CYC, P_FULG_CYC, P_DES_CYC};
        logic [6:0] r [6] = '{7'h78, 7'h78, 7'h63, 7'h18, 7'h18, 7'h38};
        for (int i = 0; i < 6; i++) begin
            apb(1, OFS_CTRL, {27'h0, 1'b1, m[i]});
            repeat (3 * p[i] + 20) @(posedge pclk);
            chk({width, period}, {w[i][15:0], p[i][15:0]});
            chk(rly(), r[i]);
            apb(1, OFS_CTRL, 0);
            repeat (5) @(posedge pclk);
            chk({gate_drive, rly()}, 0);
        end
        apb(1, OFS_CTRL, 32'h32);
        repeat (20) @(posedge pclk);
        chk(rly(), 7'h74);
        chk({voltage_scale_relays, current_scale_relays, current_source_relay}, 9'h022);
        $display("test modes done");
    endtask

    task automatic t_spark();
        apb(1, OFS_CTRL, 32'h12);
        repeat (20) @(posedge pclk);
        spike();
        repeat (400) @(posedge pclk);
        chk(period, P_CUT_CYC);
        spike();
        repeat (10) @(posedge pclk);
        chk(spark_inhibit_pulse, 1);
        repeat (90) @(posedge pclk);
        chk(gate_drive, 0);
        repeat (800) @(posedge pclk);
        chk(period, P_BIP_CYC);
        repeat (1500) @(posedge pclk);
        chk(period, P_RET_CYC);
        apb(0, OFS_STATUS, 0);
        chk(rd, 32'h11);
        $display("test spark done");
    endtask

    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, spark_detect, leakage_inhibit} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_modes();
        t_spark();
        conclude();
    end

    // Bounds the whole run; the sequence above needs about 28000 cycles.
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        conclude();
    end
endmodule
